/* verif/hbridge_link_checker.sv */
// Assertions on the power stage side of the controller-facing link.
// Assumes tb_top instantiates it beside that link, clocked by mclk.
`timescale 1ns/10ps
`include "hbridge_cfg.svh"
module hbridge_link_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwm_in_a,
	input wire logic pwm_in_b,
	input wire logic reset_n,
	input wire logic fault_status_n_i,
	input wire logic temp_warn_n_i,
	input wire logic [1:0] gate_hs,
	input wire logic [1:0] gate_ls,
	input wire logic bridge_hiz,
	input wire logic [`HB_FLT_N-1:0] fault_latched,
	input wire logic gate_supply_ok,
	input wire logic [1:0] overcurrent_high_side,
	input wire logic [1:0] overcurrent_low_side,
	input wire logic temp_above_warn,
	input wire logic temp_above_err
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_no_shoot;
		!(gate_hs[0] && gate_ls[0]) && !(gate_hs[1] && gate_ls[1]);
	endproperty
	a_no_shoot: assert property (p_no_shoot)
		else $error("both switches of one half on");
	property p_dead;
		$fell(gate_hs[0]) |-> !gate_ls[0] [*3];
	endproperty
	a_dead: assert property (p_dead)
		else $error("low side on inside dead time");
	property p_follow;
		(pwm_in_a != pwm_in_b && $stable(pwm_in_a) && !bridge_hiz) [*8]
			|-> gate_hs == {pwm_in_b, pwm_in_a}
			&& gate_ls == {pwm_in_a, pwm_in_b};
	endproperty
	a_follow: assert property (p_follow)
		else $error("gates do not follow pwm");
	property p_reset_hiz;
		!reset_n |=> bridge_hiz && gate_hs == 2'h0 && gate_ls == 2'h0;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz)
		else $error("stage driven while reset low");
	property p_status_release;
		!reset_n |=> fault_status_n_i;
	endproperty
	a_status_release: assert property (p_status_release)
		else $error("fault pin low while reset low");
	property p_fault_hiz;
		(overcurrent_high_side != 2'h0 || overcurrent_low_side != 2'h0
			|| !gate_supply_ok || temp_above_err)
			|=> bridge_hiz && gate_hs == 2'h0;
	endproperty
	a_fault_hiz: assert property (p_fault_hiz)
		else $error("stage not parked on fault");
	property p_overcur_latch;
		(overcurrent_high_side != 2'h0 || overcurrent_low_side != 2'h0)
			|=> fault_latched[`HB_FLT_OVERCUR];
	endproperty
	a_overcur_latch: assert property (p_overcur_latch)
		else $error("overcurrent not latched");
	property p_status_low;
		(reset_n && fault_latched != 3'h0) |=> !fault_status_n_i;
	endproperty
	a_status_low: assert property (p_status_low)
		else $error("fault pin high with latched fault");
	property p_warn;
		(temp_above_warn || temp_above_err) |=> !temp_warn_n_i;
	endproperty
	a_warn: assert property (p_warn)
		else $error("warning pin high while hot");
	property p_overtemp_pins;
		(reset_n && fault_latched[`HB_FLT_OVERTEMP])
			|=> !temp_warn_n_i && !fault_status_n_i;
	endproperty
	a_overtemp_pins: assert property (p_overtemp_pins)
		else $error("overtemperature error code wrong");
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the controller and power stage pair.
// Assumes package, header and interface compile first; one 20 MHz clock.
`timescale 1ns/10ps
`include "hbridge_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
	end end
module tb_top;
	logic mclk = 0;
	logic rst_n = 0;
	logic supply_up = 0, power_down_req = 0, recover = 0, warn_in = 0;
	logic auto_pwm = 0;
	logic [5:0] duty_a = 6'h10, cause = 6'h00;
	logic running, fault_seen, warn_seen, pwm_active, bridge_hiz, hiz_d;
	logic [1:0] gate_hs, gate_ls, hs_d, ls_d, pins_d;
	logic [2:0] fault_latched, latched_d, exp_lat;
	int mismatches = 0, checked = 0, ph = 0, n, t, k;
	always #25 mclk = ~mclk;
	hbridge_if i_hbridge_if();
	hbridge_if i_hbridge_if_d();
	assign pins_d = {i_hbridge_if_d.temp_warn_n_i,
		i_hbridge_if_d.fault_status_n_i};
	hbridge_controller #(.CHARGE_CYCLES(16), .RELEASE_CYCLES(40))
		i_hbridge_controller (.mclk(mclk), .rst_n(rst_n),
		.link(i_hbridge_if.host), .supply_up(supply_up),
		.power_down_req(power_down_req), .recover(recover),
		.duty_a(duty_a), .running(running), .fault_seen(fault_seen),
		.warn_seen(warn_seen), .pwm_active(pwm_active));
	hbridge_power_stage i_hbridge_power_stage (.mclk(mclk), .rst_n(rst_n),
		.link(i_hbridge_if.device), .gate_supply_ok(!cause[4]),
		.overcurrent_high_side(cause[1:0]),
		.overcurrent_low_side(cause[3:2]),
		.temp_above_warn(warn_in), .temp_above_err(cause[5]),
		.gate_hs(gate_hs), .gate_ls(gate_ls), .bridge_hiz(bridge_hiz),
		.fault_latched(fault_latched));
	// Second stage driven straight from the bench for exact timing
	hbridge_power_stage i_hbridge_power_stage_d (.mclk(mclk),
		.rst_n(rst_n), .link(i_hbridge_if_d.device),
		.gate_supply_ok(!cause[4]), .overcurrent_high_side(cause[1:0]),
		.overcurrent_low_side(cause[3:2]), .temp_above_warn(warn_in),
		.temp_above_err(cause[5]), .gate_hs(hs_d), .gate_ls(ls_d),
		.bridge_hiz(hiz_d), .fault_latched(latched_d));
	hbridge_link_checker i_hbridge_link_checker (.mclk(mclk),
		.rst_n(rst_n), .pwm_in_a(i_hbridge_if.pwm_in_a),
		.pwm_in_b(i_hbridge_if.pwm_in_b), .reset_n(i_hbridge_if.reset_n),
		.fault_status_n_i(i_hbridge_if.fault_status_n_i),
		.temp_warn_n_i(i_hbridge_if.temp_warn_n_i), .gate_hs(gate_hs),
		.gate_ls(gate_ls), .bridge_hiz(bridge_hiz),
		.fault_latched(fault_latched), .gate_supply_ok(!cause[4]),
		.overcurrent_high_side(cause[1:0]),
		.overcurrent_low_side(cause[3:2]),
		.temp_above_warn(warn_in), .temp_above_err(cause[5]));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task cyc(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task watch(input int c, output int tg);
		logic p;
		tg = 0;
		p = i_hbridge_if.pwm_in_a;
		repeat (c) begin
			cyc(1);
			if (i_hbridge_if.pwm_in_a !== p) tg++;
			p = i_hbridge_if.pwm_in_a;
		end
	endtask
	task set_pwm(input logic a, input logic b);
		i_hbridge_if_d.pwm_in_a = a;
		i_hbridge_if_d.pwm_in_b = b;
	endtask
	task pulse_d(input int lo, input int hi);
		i_hbridge_if_d.reset_n = 0;
		cyc(lo);
		i_hbridge_if_d.reset_n = 1;
		cyc(hi);
	endtask
	task print_verdict;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Never holds a level for long: idle switching keeps bootstrap charged
	always @(posedge mclk) begin
		#1;
		if (auto_pwm) begin
			ph = ph + 1;
			set_pwm(ph[2], !ph[2]);
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		i_hbridge_if_d.reset_n = 0;
		set_pwm(0, 0);
		repeat (16) @(posedge mclk);
		#1;
		rst_n = 1;
		cyc(2);
		`CHK("hiz", 1'b1, bridge_hiz)
		`CHK("gates", 4'h0, {gate_hs, gate_ls})
		`CHK("fault pin", 1'b1, i_hbridge_if.fault_status_n_i)
		supply_up = 1;
		watch(30, t);
		`CHK("pwm before release", 1'b1, t > 0)
		`CHK("early release", 1'b0, i_hbridge_if.reset_n)
		n = 0;
		while (running !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		`CHK("running", 1'b1, running)
		duty_a = 6'h3f;
		cyc(150);
		`CHK("stage live", 1'b0, bridge_hiz)
		auto_pwm = 1;
		cyc(10);
		pulse_d(1, 10);
		auto_pwm = 0;
		cyc(1);
		set_pwm(1, 0);
		cyc(10);
		`CHK("a up b down", 4'h6, {hs_d, ls_d})
		set_pwm(0, 1);
		cyc(3);
		`CHK("dead a", 2'h0, {hs_d[0], ls_d[0]})
		cyc(7);
		`CHK("a down b up", 4'h9, {hs_d, ls_d})
		auto_pwm = 1;
		i_hbridge_if_d.reset_n = 0;
		cyc(2);
		`CHK("reset park", 5'h10, {hiz_d, hs_d, ls_d})
		i_hbridge_if_d.reset_n = 1;
		cyc(8);
		`CHK("resume", 1'b0, hiz_d)
		for (k = 0; k < 6; k++) begin
			cause = 6'h01 << k;
			cyc(3);
			exp_lat = k < 4 ? 3'h1 : (k == 4 ? 3'h2 : 3'h4);
			`CHK("latch", exp_lat, latched_d)
			`CHK("fault park", 1'b1, hiz_d)
			`CHK("pins", k == 5 ? 2'h0 : 2'h2, pins_d)
			pulse_d(2, 6);
			`CHK("rise refused", 1'b1, hiz_d)
			`CHK("fault seen", 1'b1, fault_seen)
			cause = 6'h00;
			cyc(4);
			`CHK("still parked", 1'b1, hiz_d)
			i_hbridge_if_d.reset_n = 0;
			cyc(2);
			`CHK("pin released", 1'b1, pins_d[0])
			`CHK("latch cleared", 3'h0, latched_d)
			i_hbridge_if_d.reset_n = 1;
			cyc(6);
			`CHK("rearmed", 1'b0, hiz_d)
			recover = 1;
			cyc(1);
			recover = 0;
			cyc(4);
			`CHK("recovered", 1'b1, i_hbridge_if.reset_n)
		end
		warn_in = 1;
		cyc(3);
		`CHK("warn code", 2'h1, pins_d)
		`CHK("warn seen", 1'b1, warn_seen)
		warn_in = 0;
		cyc(3);
		`CHK("normal code", 2'h3, pins_d)
		power_down_req = 1;
		n = 0;
		while (i_hbridge_if.reset_n !== 1'b0 && n < 10) begin
			cyc(1);
			n++;
		end
		`CHK("reset dropped", 1'b0, i_hbridge_if.reset_n)
		watch(54, t);
		`CHK("pwm after reset", 1'b1, t > 0)
		cyc(150);
		`CHK("stopped", 2'h0, {running, pwm_active})
		print_verdict;
	end
	// Whole sequence takes about 650 cycles
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		print_verdict;
	end
endmodule

/* verilog/hbridge_cfg.svh */
// Timing counts and sizes for the H-bridge control pair.
// Assumes a single 20 MHz system clock feeding both ends.
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define HB_CLK_HZ 20000000
`define HB_CLK_PER_MHZ 20

// ----------------------------------------
// Power-up sequencing times
// ----------------------------------------
`define HB_CHARGE_US 800
`define HB_RELEASE_US 1000

// ----------------------------------------
// Modulator
// ----------------------------------------
`define HB_PWM_FREQ_HZ 370000
`define HB_PWM_CNT_W 6
`define HB_PWM_DUTY_MIN 6'h01
`define HB_STOP_PERIODS 2

// ----------------------------------------
// Dead time between switch hand-overs
// ----------------------------------------
`define HB_DEAD_CYCLES 3'h3
`define HB_DEAD_W 3

// ----------------------------------------
// Fault latch positions
// ----------------------------------------
`define HB_FLT_OVERCUR 0
`define HB_FLT_UV 1
`define HB_FLT_OVERTEMP 2
`define HB_FLT_N 3

`endif

/* verilog/hbridge_controller.sv */
// Modulator and system controller end of the H-bridge link.
// Assumes user requests are synchronous to mclk.
`timescale 1ns/10ps
`include "hbridge_cfg.svh"
module hbridge_controller
	import hbridge_pkg::*;
#(
	parameter int CHARGE_CYCLES = `HB_CHARGE_US * `HB_CLK_PER_MHZ,
	parameter int RELEASE_CYCLES = `HB_RELEASE_US * `HB_CLK_PER_MHZ
) (
	input wire logic mclk,
	input wire logic rst_n,
	hbridge_if.host link,
	input wire logic supply_up,
	input wire logic power_down_req,
	input wire logic recover,
	input wire logic [`HB_PWM_CNT_W-1:0] duty_a,
	output logic running,
	output logic fault_seen,
	output logic warn_seen,
	output logic pwm_active
);
	localparam int PERIOD_I = `HB_CLK_HZ / `HB_PWM_FREQ_HZ;
	localparam logic [`HB_PWM_CNT_W-1:0] PERIOD =
		PERIOD_I[`HB_PWM_CNT_W-1:0];
	localparam int STOP_I = `HB_STOP_PERIODS * PERIOD_I;
	localparam int WAIT_I = (CHARGE_CYCLES > RELEASE_CYCLES) ?
		CHARGE_CYCLES : RELEASE_CYCLES;
	localparam logic [15:0] WAIT_CYC = WAIT_I[15:0];
	localparam logic [15:0] STOP_CYC = STOP_I[15:0];

	ctl_state_type state_r;
	ctl_state_type state_nxt;
	logic [15:0] tmr_r;
	logic [`HB_PWM_CNT_W-1:0] cnt_r;
	logic [`HB_PWM_CNT_W-1:0] duty;
	logic pwm_on;
	logic pwm_a_r;
	logic pwm_b_r;
	logic reset_n_r;

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CTL_OFF: begin
				if (supply_up && !power_down_req) begin
					state_nxt = CTL_CHARGE;
				end
			end
			CTL_CHARGE: begin
				if (power_down_req || !supply_up) begin
					state_nxt = CTL_STOP;
				end else if (tmr_r >= WAIT_CYC) begin
					state_nxt = CTL_RUN;
				end
			end
			CTL_RUN: begin
				if (power_down_req || !supply_up) begin
					state_nxt = CTL_STOP;
				end else if (!link.fault_status_n_i) begin
					state_nxt = CTL_FAULT;
				end
			end
			CTL_FAULT: begin
				if (power_down_req || !supply_up) begin
					state_nxt = CTL_STOP;
				end else if (recover) begin
					state_nxt = CTL_RUN;
				end
			end
			CTL_STOP: begin
				if (tmr_r >= STOP_CYC) begin
					state_nxt = CTL_OFF;
				end
			end
			default: begin
				state_nxt = CTL_OFF;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CTL_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer restarts on each state change; saturates
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_r <= 16'h0000;
		end else if (state_nxt != state_r) begin
			tmr_r <= 16'h0000;
		end else if (tmr_r != 16'hffff) begin
			tmr_r <= tmr_r + 16'h0001;
		end
	end

	// Reset high only while running; it drops on the same edge
	// the stop begins, while PWM still streams
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_n_r <= 1'b0;
		end else begin
			reset_n_r <= (state_nxt == CTL_RUN);
		end
	end

	// ----------------------------------------
	// Modulator
	// ----------------------------------------
	assign pwm_on = (state_r != CTL_OFF);

	// Duty clamped so neither input can sit high for a full period
	always_comb begin
		duty = duty_a;
		if (duty_a < `HB_PWM_DUTY_MIN) begin
			duty = `HB_PWM_DUTY_MIN;
		end else if (duty_a > PERIOD - `HB_PWM_DUTY_MIN) begin
			duty = PERIOD - `HB_PWM_DUTY_MIN;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			pwm_a_r <= 1'b0;
			pwm_b_r <= 1'b0;
		end else if (!pwm_on) begin
			cnt_r <= '0;
			pwm_a_r <= 1'b0;
			pwm_b_r <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == PERIOD - 1'b1) ? '0 : cnt_r + 1'b1;
			pwm_a_r <= (cnt_r < duty);
			pwm_b_r <= (cnt_r >= duty);
		end
	end

	// ----------------------------------------
	// User status
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			running <= 1'b0;
			fault_seen <= 1'b0;
			warn_seen <= 1'b0;
			pwm_active <= 1'b0;
		end else begin
			running <= (state_nxt == CTL_RUN);
			pwm_active <= pwm_on;
			warn_seen <= ~link.temp_warn_n_i;
			if (state_r == CTL_RUN && !link.fault_status_n_i) begin
				fault_seen <= 1'b1;
			end else if (recover) begin
				fault_seen <= 1'b0;
			end
		end
	end

	assign link.pwm_in_a = pwm_a_r;
	assign link.pwm_in_b = pwm_b_r;
	assign link.reset_n = reset_n_r;
endmodule

/* verilog/hbridge_half_drive.sv */
// One half-bridge gate driver with dead time on every hand-over.
// Assumes pwm_level and enable are synchronous to mclk.
`timescale 1ns/10ps
`include "hbridge_cfg.svh"
module hbridge_half_drive
	import hbridge_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic pwm_level,
	output logic hs_on,
	output logic ls_on
);
	half_state_type cur_r;
	half_state_type target;
	logic [`HB_DEAD_W-1:0] dead_r;

	assign target = pwm_level ? HALF_HIGH : HALF_LOW;

	// ----------------------------------------
	// Switch sequencing
	// ----------------------------------------
	// Disable is immediate; turn-on always waits out the dead time
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r <= HALF_OFF;
			dead_r <= `HB_DEAD_CYCLES;
			hs_on <= 1'b0;
			ls_on <= 1'b0;
		end else if (!enable) begin
			cur_r <= HALF_OFF;
			dead_r <= `HB_DEAD_CYCLES;
			hs_on <= 1'b0;
			ls_on <= 1'b0;
		end else begin
			unique case (cur_r)
				HALF_OFF: begin
					if (dead_r == '0) begin
						cur_r <= target;
						hs_on <= (target == HALF_HIGH);
						ls_on <= (target == HALF_LOW);
					end else begin
						dead_r <= dead_r - 1'b1;
					end
				end
				HALF_HIGH, HALF_LOW: begin
					if (cur_r != target) begin
						cur_r <= HALF_OFF;
						dead_r <= `HB_DEAD_CYCLES;
						hs_on <= 1'b0;
						ls_on <= 1'b0;
					end
				end
				default: begin
					cur_r <= HALF_OFF;
					dead_r <= `HB_DEAD_CYCLES;
					hs_on <= 1'b0;
					ls_on <= 1'b0;
				end
			endcase
		end
	end
endmodule

/* verilog/hbridge_if.sv */
// Link between the modulator/controller and the power stage.
// Status pins are open drain with a pull-up modelled here.
`timescale 1ns/10ps
interface hbridge_if;
	logic pwm_in_a;
	logic pwm_in_b;
	logic reset_n;
	logic fault_status_n_o;
	logic fault_status_n_oe;
	logic fault_status_n_i;
	logic temp_warn_n_o;
	logic temp_warn_n_oe;
	logic temp_warn_n_i;

	// ----------------------------------------
	// Pull-up resolution of the open-drain pins
	// ----------------------------------------
	assign fault_status_n_i = fault_status_n_oe ? fault_status_n_o : 1'b1;
	assign temp_warn_n_i = temp_warn_n_oe ? temp_warn_n_o : 1'b1;

	modport device (
		input pwm_in_a,
		input pwm_in_b,
		input reset_n,
		output fault_status_n_o,
		output fault_status_n_oe,
		input fault_status_n_i,
		output temp_warn_n_o,
		output temp_warn_n_oe,
		input temp_warn_n_i
	);

	modport host (
		output pwm_in_a,
		output pwm_in_b,
		output reset_n,
		input fault_status_n_i,
		input temp_warn_n_i
	);
endinterface

/* verilog/hbridge_pkg.sv */
// Types shared by both ends of the H-bridge control link.
// Assumes nothing beyond the config header for numbers.
package hbridge_pkg;

	// ----------------------------------------
	// Half-bridge switch state
	// ----------------------------------------
	typedef enum logic [1:0] {
		HALF_OFF = 2'b00,
		HALF_HIGH = 2'b01,
		HALF_LOW = 2'b10
	} half_state_type;

	// ----------------------------------------
	// Output stage state
	// ----------------------------------------
	typedef enum logic [1:0] {
		STAGE_HIZ = 2'b00,
		STAGE_RUN = 2'b01,
		STAGE_PROTECT = 2'b10
	} stage_state_type;

	// ----------------------------------------
	// Controller sequence
	// ----------------------------------------
	typedef enum logic [2:0] {
		CTL_OFF = 3'b000,
		CTL_CHARGE = 3'b001,
		CTL_RUN = 3'b010,
		CTL_FAULT = 3'b011,
		CTL_STOP = 3'b100
	} ctl_state_type;

endpackage

/* verilog/hbridge_power_stage.sv */
// Control and protection logic of the two-half-bridge power stage.
// Assumes link inputs are synchronous to mclk; fault detectors are
// plain synchronous levels from the analogue side.
`timescale 1ns/10ps
`include "hbridge_cfg.svh"

module hbridge_power_stage
	import hbridge_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	hbridge_if.device link,
	input wire logic gate_supply_ok,
	input wire logic [1:0] overcurrent_high_side,
	input wire logic [1:0] overcurrent_low_side,
	input wire logic temp_above_warn,
	input wire logic temp_above_err,
	output logic [1:0] gate_hs,
	output logic [1:0] gate_ls,
	output logic bridge_hiz,
	output logic [`HB_FLT_N-1:0] fault_latched
);
	stage_state_type stage_r;
	stage_state_type stage_nxt;
	logic reset_pin_r;
	logic reset_fall;
	logic reset_rise;
	logic [`HB_FLT_N-1:0] cause;
	logic [`HB_FLT_N-1:0] fault_lat_r;
	logic latch_clear;
	logic any_fault;
	logic drive_en;
	logic [1:0] pwm_vec;
	logic fs_oe_r;
	logic tw_oe_r;
	logic bridge_hiz_r;

	// ----------------------------------------
	// Reset pin edges
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_pin_r <= 1'b0;
		end else begin
			reset_pin_r <= link.reset_n;
		end
	end

	assign reset_fall = reset_pin_r & ~link.reset_n;
	assign reset_rise = ~reset_pin_r & link.reset_n;

	// ----------------------------------------
	// Fault causes
	// ----------------------------------------
	assign cause[`HB_FLT_OVERCUR] =
		|{overcurrent_high_side, overcurrent_low_side};
	assign cause[`HB_FLT_UV] = ~gate_supply_ok;
	assign cause[`HB_FLT_OVERTEMP] = temp_above_err;

	// Clear on the reset fall, and while reset sits low with the
	// cause gone, so a held reset at power-up leaves clean latches
	assign latch_clear = reset_fall | ~link.reset_n;

	// ----------------------------------------
	// Fault latches
	// ----------------------------------------
	// A cause still present wins over the clear, so a fault that
	// persists through a reset pulse is never lost
	genvar gi;
	generate
		for (gi = 0; gi < `HB_FLT_N; gi++) begin : g_latch
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					fault_lat_r[gi] <= 1'b0;
				end else if (cause[gi]) begin
					fault_lat_r[gi] <= 1'b1;
				end else if (latch_clear) begin
					fault_lat_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign any_fault = |fault_lat_r | |cause;
	assign fault_latched = fault_lat_r;

	// ----------------------------------------
	// Output stage state
	// ----------------------------------------
	always_comb begin
		stage_nxt = stage_r;
		unique case (stage_r)
			STAGE_HIZ: begin
				if (reset_rise && !any_fault) begin
					stage_nxt = STAGE_RUN;
				end
			end
			STAGE_RUN: begin
				if (!link.reset_n) begin
					stage_nxt = STAGE_HIZ;
				end else if (any_fault) begin
					stage_nxt = STAGE_PROTECT;
				end
			end
			STAGE_PROTECT: begin
				if (!link.reset_n) begin
					stage_nxt = STAGE_HIZ;
				end
			end
			default: begin
				stage_nxt = STAGE_HIZ;
			end
		endcase
	end

	// Power-up always lands in Hi-Z; only a reset rise arms it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage_r <= STAGE_HIZ;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	// ----------------------------------------
	// Bridge drive
	// ----------------------------------------
	// Enable is cut in the same cycle a cause appears, ahead of the
	// state register, to lose no cycle before Hi-Z
	assign drive_en = (stage_r == STAGE_RUN) && link.reset_n &&
		!any_fault;
	assign pwm_vec = {link.pwm_in_b, link.pwm_in_a};

	// Each half follows its own input: A high drives A to supply,
	// B low drives B to ground, and the mirror case likewise
	generate
		for (gi = 0; gi < 2; gi++) begin : g_half
			hbridge_half_drive u_half (
				.mclk(mclk),
				.rst_n(rst_n),
				.enable(drive_en),
				.pwm_level(pwm_vec[gi]),
				.hs_on(gate_hs[gi]),
				.ls_on(gate_ls[gi])
			);
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bridge_hiz_r <= 1'b1;
		end else begin
			bridge_hiz_r <= ~drive_en;
		end
	end

	assign bridge_hiz = bridge_hiz_r;

	// ----------------------------------------
	// Status pins
	// ----------------------------------------
	// Reset low releases the pin whatever is latched; this keeps
	// the low/low overtemperature code off the pins while reset is low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fs_oe_r <= 1'b0;
		end else if (!link.reset_n) begin
			fs_oe_r <= 1'b0;
		end else begin
			fs_oe_r <= any_fault;
		end
	end

	// Warning tracks temperature; an overtemperature latch keeps it
	// low so the pair reads as error even after cooling
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tw_oe_r <= 1'b0;
		end else begin
			tw_oe_r <= temp_above_warn | temp_above_err |
				(fault_lat_r[`HB_FLT_OVERTEMP] & link.reset_n);
		end
	end

	assign link.fault_status_n_o = 1'b0;
	assign link.fault_status_n_oe = fs_oe_r;
	assign link.temp_warn_n_o = 1'b0;
	assign link.temp_warn_n_oe = tw_oe_r;
endmodule
